// >>> hw/nvc_flash_data_memory_ctrl.sv
// Flash data memory controller: 64-byte array behind three registers.
// Functional notes
// - Array reached only through dedicated registers
// - Load address, then set read strobe
// - Read data appears at once, held
// - Core stalled during a read cycle
// - Read starts only from single-bit-set instruction
// - Erase whole row, program single byte
// - 64 bytes as eight rows of eight
// - Erase row chosen by address bits 5:3
// - Erase or write needs exact unlock sequence
// - Erase select cleared unless unlock follows
// - Unlock cleared unless strobe follows next
// - Unlock and strobe need single-bit-set writes
// - Core stalled for the erase cycle
// - Core stalled for the byte write
// - Instruction after strobe needs no padding
// - Code protection never blocks array access
`timescale 1ns/1ps
`include "nvc_regs.svh"

module nvc_flash_data_memory_ctrl #(
    parameter int ERASE_CYCLES =
        (`NVC_ERASE_US * 1000 + `NVC_CLK_NS - 1) / `NVC_CLK_NS,
    parameter int PROG_CYCLES  =
        (`NVC_PROG_US * 1000 + `NVC_CLK_NS - 1) / `NVC_CLK_NS
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire nvc_pkg::nvc_bus_req_t bus_req,
    input  wire logic                 instr_step,
    output logic [7:0]                rdata,
    output logic                      stall
);

    //------------------------------------------------------------------
    // Constants
    //------------------------------------------------------------------
    localparam int CNT_W = $clog2(ERASE_CYCLES + PROG_CYCLES + 2);
    localparam int ROWS  = 8;
    localparam int BYTES = 8;

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    nvc_pkg::nvc_state_t state_ff;
    logic [CNT_W-1:0]    cnt_ff;
    logic [5:0]          addr_ff;
    logic [7:0]          data_ff;
    logic [7:0]          rdata_ff;
    logic                free_ff;
    logic                write_unlock_bit_ff;
    logic                wr_ff;
    logic                rd_ff;
    logic                free_wait_ff;
    logic                write_unlock_bit_wait_ff;
    logic [7:0]          mem [ROWS*BYTES];

    // Returns the control register value as software sees it.
    function automatic logic [7:0] ctrl_image(input logic fr, input logic we,
                                              input logic w, input logic r);
        logic [7:0] v;
        v = 8'h00;
        v[`NVC_BIT_FREE] = fr;
        v[`NVC_BIT_WRITE_UNLOCK_BIT] = we;
        v[`NVC_BIT_WR]   = w;
        v[`NVC_BIT_RD]   = r;
        return v;
    endfunction : ctrl_image

    //------------------------------------------------------------------
    // Access decode
    //------------------------------------------------------------------
    logic       idle;
    logic       ctl_wr;
    logic       bset;
    logic [7:0] ctl_now;
    logic [7:0] rising;
    logic       set_rd;
    logic       set_write_unlock_bit;
    logic       set_wr;
    logic       start_rd;
    logic       start_cyc;
    logic       cyc_done;
    logic [7:0] mem_rd;

    // Writes are refused while a cycle runs; the core is stalled then
    // anyway, so this only guards against a misbehaving master.
    assign idle     = (state_ff == nvc_pkg::NVC_IDLE);
    assign ctl_wr   = idle && bus_req.wr &&
                      (bus_req.addr == `NVC_OFS_CTRL);
    assign bset     = ctl_wr && bus_req.bitset;
    assign ctl_now  = ctrl_image(free_ff, write_unlock_bit_ff, wr_ff, rd_ff);
    assign rising   = bus_req.wdata & ~ctl_now;
    assign set_rd   = bset && rising[`NVC_BIT_RD];
    assign set_write_unlock_bit = bset && rising[`NVC_BIT_WRITE_UNLOCK_BIT];
    assign set_wr   = bset && rising[`NVC_BIT_WR];
    assign start_rd = set_rd;
    // A strobe without a live unlock bit is simply dropped.
    assign start_cyc = set_wr && write_unlock_bit_ff;
    assign cyc_done  = (state_ff == nvc_pkg::NVC_ERASE ||
                        state_ff == nvc_pkg::NVC_PROG) &&
                       (cnt_ff == '0);
    assign mem_rd    = mem[addr_ff];

    //------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------
    // One state per cycle type; the counter times the cell operation.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= nvc_pkg::NVC_IDLE;
            cnt_ff   <= '0;
        end else begin
            case (state_ff)
                nvc_pkg::NVC_IDLE: begin
                    if (start_rd) begin
                        state_ff <= nvc_pkg::NVC_READ;
                        cnt_ff   <= CNT_W'(`NVC_READ_CYCLES - 1);
                    end else if (start_cyc && free_ff) begin
                        state_ff <= nvc_pkg::NVC_ERASE;
                        cnt_ff   <= CNT_W'(ERASE_CYCLES - 1);
                    end else if (start_cyc) begin
                        state_ff <= nvc_pkg::NVC_PROG;
                        cnt_ff   <= CNT_W'(PROG_CYCLES - 1);
                    end
                end
                nvc_pkg::NVC_READ,
                nvc_pkg::NVC_ERASE,
                nvc_pkg::NVC_PROG: begin
                    if (cnt_ff == '0) begin
                        state_ff <= nvc_pkg::NVC_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= nvc_pkg::NVC_IDLE;
                end
            endcase
        end
    end

    // Stall is decoded straight from the state register, so the instruction after the strobe is held
    // off cleanly and then runs once the cycle ends.
    assign stall = !idle;

    //------------------------------------------------------------------
    // Address and data registers
    //------------------------------------------------------------------
    // Only six address bits exist; upper bits of a write are dropped.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_ff <= `NVC_RST_ADDR;
        end else if (idle && bus_req.wr &&
                     bus_req.addr == `NVC_OFS_ADDR) begin
            addr_ff <= bus_req.wdata[5:0];
        end
    end

    // Read data lands here at once and stays until the next load.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_ff <= `NVC_RST_DATA;
        end else if (start_rd) begin
            data_ff <= mem_rd;
        end else if (idle && bus_req.wr &&
                     bus_req.addr == `NVC_OFS_DATA) begin
            data_ff <= bus_req.wdata;
        end
    end

    //------------------------------------------------------------------
    // Control bits and unlock timing
    //------------------------------------------------------------------
    // The erase select accepts any write; an ordinary write may also
    // clear the unlock bit, but only a bit-set may raise it or a strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            free_ff <= 1'b0;
        end else if (cyc_done) begin
            free_ff <= 1'b0;
        end else if (free_wait_ff && instr_step && !set_write_unlock_bit) begin
            free_ff <= 1'b0;
        end else if (ctl_wr) begin
            free_ff <= bus_req.wdata[`NVC_BIT_FREE];
        end
    end

    // A write to the control register is itself an instruction step,
    // so the step that sets a bit also re-arms its watch.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            free_wait_ff <= 1'b0;
            write_unlock_bit_wait_ff <= 1'b0;
        end else if (instr_step) begin
            free_wait_ff <= ctl_wr && rising[`NVC_BIT_FREE];
            write_unlock_bit_wait_ff <= set_write_unlock_bit;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            write_unlock_bit_ff <= 1'b0;
        end else if (cyc_done) begin
            write_unlock_bit_ff <= 1'b0;
        end else if (set_write_unlock_bit) begin
            write_unlock_bit_ff <= 1'b1;
        end else if (free_wait_ff && instr_step) begin
            write_unlock_bit_ff <= 1'b0;
        end else if (write_unlock_bit_wait_ff && instr_step && !set_wr) begin
            write_unlock_bit_ff <= 1'b0;
        end else if (ctl_wr && !bus_req.wdata[`NVC_BIT_WRITE_UNLOCK_BIT]) begin
            write_unlock_bit_ff <= 1'b0;
        end
    end

    // Strobes stay set while their cycle runs and drop at the end.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ff <= 1'b0;
        end else if (cyc_done) begin
            wr_ff <= 1'b0;
        end else if (start_cyc) begin
            wr_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ff <= 1'b0;
        end else begin
            rd_ff <= start_rd;
        end
    end

    //------------------------------------------------------------------
    // Array
    //------------------------------------------------------------------
    // Nonvolatile contents are not reset.  There is no protection gate:
    // the core may always read and write the array.
    always_ff @(posedge ref_clk) begin
        if (cyc_done && state_ff == nvc_pkg::NVC_ERASE) begin
            for (int i = 0; i < BYTES; i++) begin
                mem[{addr_ff[5:3], 3'(i)}] <= `NVC_ERASED;
            end
        end else if (cyc_done) begin
            mem[addr_ff] <= data_ff;
        end
    end

    //------------------------------------------------------------------
    // Register read port
    //------------------------------------------------------------------
    // The array has no address of its own on this port.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `NVC_OFS_ADDR: rdata_ff <= {2'b00, addr_ff};
                `NVC_OFS_DATA: rdata_ff <= data_ff;
                `NVC_OFS_CTRL: rdata_ff <= ctl_now;
                default:       rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata = rdata_ff;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    // All checks share the one clock and rest while reset is high.
    default clocking nvc_dcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_rd_bitset_only;
        (ctl_wr && !bus_req.bitset) |=> !stall;
    endproperty
    a_rd_bitset_only: assert property (p_rd_bitset_only)
        else $error("read or cycle started without bit-set");
    property p_rd_stall;
        start_rd |=> stall ##1 !stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall)
        else $error("read stall not one cycle");
    property p_rd_data;
        start_rd |=> (data_ff == $past(mem_rd)) [*2];
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read data not loaded or not held");
    property p_locked;
        (set_wr && !write_unlock_bit_ff) |=> !stall && !wr_ff;
    endproperty
    a_locked: assert property (p_locked)
        else $error("cycle started while locked");
    property p_free_drop;
        (free_wait_ff && instr_step && !set_write_unlock_bit) |=> !free_ff;
    endproperty
    a_free_drop: assert property (p_free_drop)
        else $error("erase select survived missed unlock");
    property p_write_unlock_bit_drop;
        (write_unlock_bit_wait_ff && instr_step && !set_wr && !set_write_unlock_bit) |=> !write_unlock_bit_ff;
    endproperty
    a_write_unlock_bit_drop: assert property (p_write_unlock_bit_drop)
        else $error("unlock survived missed strobe");
    property p_cyc_stall;
        start_cyc |=> stall [*2];
    endproperty
    a_cyc_stall: assert property (p_cyc_stall)
        else $error("core not stalled during cycle");
    property p_done_clear;
        cyc_done |=> !wr_ff && !write_unlock_bit_ff && !free_ff && !stall;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("bits not cleared after cycle");
    property p_prog_byte;
        (cyc_done && state_ff == nvc_pkg::NVC_PROG)
            |=> mem[$past(addr_ff)] == $past(data_ff);
    endproperty
    a_prog_byte: assert property (p_prog_byte)
        else $error("byte not programmed");

    c_read:  cover property (start_rd);
    c_erase: cover property (cyc_done && state_ff == nvc_pkg::NVC_ERASE);
    c_prog:  cover property (cyc_done && state_ff == nvc_pkg::NVC_PROG);
    c_lock:  cover property (set_wr && !write_unlock_bit_ff);

endmodule : nvc_flash_data_memory_ctrl

// >>> hw/nvc_regs.svh
// Register offsets, control bit positions, reset values and cycle timing.
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH

// Register offsets on the plain register port.
`define NVC_OFS_ADDR     4'h0
`define NVC_OFS_DATA     4'h1
`define NVC_OFS_CTRL     4'h2

// Control register bit positions.
`define NVC_BIT_RD       0
`define NVC_BIT_WR       1
`define NVC_BIT_WRITE_UNLOCK_BIT     2
`define NVC_BIT_FREE     3

// Reset values and the value of an erased cell.
`define NVC_RST_ADDR     6'h00
`define NVC_RST_DATA     8'h00
`define NVC_ERASED       8'hff

// Clock period and cell timing.
`define NVC_CLK_NS       8
`define NVC_ERASE_US     2000
`define NVC_PROG_US      2000
`define NVC_READ_CYCLES  1

`endif

// >>> hw/nvc_pkg.sv
// Types shared by the flash data memory controller.
package nvc_pkg;

    // One register access from the core.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       bitset;
    } nvc_bus_req_t;

    // Cycle currently run by the controller.
    typedef enum logic [1:0] {
        NVC_IDLE,
        NVC_READ,
        NVC_ERASE,
        NVC_PROG
    } nvc_state_t;

endpackage : nvc_pkg

// >>> sim/nvc_core_model.sv
// CPU core model that issues register accesses and instruction steps.
`timescale 1ns/1ps
`include "nvc_regs.svh"

module nvc_core_model (
    input  wire logic             ref_clk,
    input  wire logic             stall,
    input  wire logic [7:0]       rdata,
    output nvc_pkg::nvc_bus_req_t bus_req,
    output logic                  instr_step
);
    int stall_seen;

    // The bus is quiet until the first instruction.
    initial begin
        bus_req    = '0;
        instr_step = 1'b0;
        stall_seen = 0;
    end

    // ------------------------------------------------------------------
    // Single accesses
    // ------------------------------------------------------------------

    // One instruction that writes a register, taken at the next edge.
    task automatic put(input logic [3:0] a, input logic [7:0] d,
                       input logic bs);
        bus_req    <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bitset: bs};
        instr_step <= 1'b1;
        @(posedge ref_clk);
    endtask : put

    // Register read; the answer stands only in the cycle after the strobe.
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        bus_req    <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1,
                        bitset: 1'b0};
        instr_step <= 1'b0;
        @(posedge ref_clk);
        bus_req    <= '0;
        @(posedge ref_clk);
        d = rdata;
    endtask : get

    // Release the bus and hold while stalled, counting stalled cycles.
    task automatic settle();
        bus_req    <= '0;
        instr_step <= 1'b0;
        stall_seen = 0;
        @(posedge ref_clk);
        while (stall === 1'b1 && stall_seen < 100) begin
            stall_seen++;
            @(posedge ref_clk);
        end
    endtask : settle

    // ------------------------------------------------------------------
    // Documented sequences
    // ------------------------------------------------------------------

    // Row erase: address, erase select, unlock, strobe on adjacent steps.
    task automatic erase_row(input logic [5:0] a);
        put(`NVC_OFS_ADDR, {2'b00, a}, 1'b0);
        put(`NVC_OFS_CTRL, 8'h08, 1'b0);
        put(`NVC_OFS_CTRL, 8'h0c, 1'b1);
        put(`NVC_OFS_CTRL, 8'h0e, 1'b1);
        settle();
    endtask : erase_row

    // Byte write: the caller erases the row first and keeps what it needs.
    task automatic prog_byte(input logic [5:0] a, input logic [7:0] d);
        put(`NVC_OFS_ADDR, {2'b00, a}, 1'b0);
        put(`NVC_OFS_DATA, d, 1'b0);
        put(`NVC_OFS_CTRL, 8'h04, 1'b1);
        put(`NVC_OFS_CTRL, 8'h06, 1'b1);
        settle();
    endtask : prog_byte

    // Array read through the address register and the read strobe.
    task automatic read_byte(input logic [5:0] a, output logic [7:0] d);
        put(`NVC_OFS_ADDR, {2'b00, a}, 1'b0);
        put(`NVC_OFS_CTRL, 8'h01, 1'b1);
        settle();
        get(`NVC_OFS_DATA, d);
    endtask : read_byte
endmodule : nvc_core_model

// >>> sim/tb_flash_data_memory_ctrl.sv
// Self-checking testbench for the flash data memory controller.
`timescale 1ns/1ps
`include "nvc_regs.svh"

module tb_flash_data_memory_ctrl;
    localparam int NCYC = 4;

    logic                  ref_clk;
    logic                  rst;
    nvc_pkg::nvc_bus_req_t bus_req;
    logic                  instr_step;
    logic                  stall;
    logic [7:0]            rdata;
    logic [7:0]            got;
    logic [7:0]            d;
    logic [5:0]            a;
    logic [31:0]           lfsr;
    logic [7:0]            mem_m [64];
    int                    err_count;
    int                    check_count;

    nvc_flash_data_memory_ctrl #(
        .ERASE_CYCLES(NCYC),
        .PROG_CYCLES (NCYC)
    ) DUT (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .bus_req   (bus_req),
        .instr_step(instr_step),
        .rdata     (rdata),
        .stall     (stall)
    );

    nvc_core_model core (
        .ref_clk   (ref_clk),
        .stall     (stall),
        .rdata     (rdata),
        .bus_req   (bus_req),
        .instr_step(instr_step)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Free-running 125 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // A hang far beyond the expected run of under 800 cycles ends the run.
    initial begin
        #200000;
        err_count++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------

    // Scenarios run in order; the array model starts unknown like the cells.
    initial begin
        err_count = 0;
        check_count = 0;
        lfsr = 32'haacb1dec;
        rst = 1'b1;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            core.get(4'(i), got);
            check(got, 8'h00);
        end
        core.put(`NVC_OFS_ADDR, 8'hff, 1'b0);
        core.get(`NVC_OFS_ADDR, got);
        check(got, 8'h3f);
        // Erase each row through a random address inside it.
        for (int r = 0; r < 8; r++) begin
            lfsr = lfsr_next(lfsr);
            core.erase_row({r[2:0], lfsr[2:0]});
            check(8'(core.stall_seen), 8'(NCYC));
            core.get(`NVC_OFS_CTRL, got);
            check(got, 8'h00);
            for (int b = 0; b < 8; b++) mem_m[r * 8 + b] = `NVC_ERASED;
        end
        // Random byte writes, each read back at once.
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            a = lfsr[5:0];
            d = lfsr[15:8];
            core.prog_byte(a, d);
            check(8'(core.stall_seen), 8'(NCYC));
            mem_m[a] = d;
            // Spoil the data register so that a lost read cannot pass.
            core.put(`NVC_OFS_DATA, ~d, 1'b0);
            core.read_byte(a, got);
            check(got, d);
            check(8'(core.stall_seen), 8'h01);
        end
        // Broken unlock sequences must leave the array alone.
        core.put(`NVC_OFS_CTRL, 8'h04, 1'b0);
        core.get(`NVC_OFS_CTRL, got);
        check(got, 8'h00);
        core.put(`NVC_OFS_CTRL, 8'h02, 1'b1);
        core.settle();
        check(8'(core.stall_seen), 8'h00);
        core.put(`NVC_OFS_CTRL, 8'h04, 1'b1);
        core.put(`NVC_OFS_ADDR, {2'b00, a}, 1'b0);
        core.get(`NVC_OFS_CTRL, got);
        check(got, 8'h00);
        core.put(`NVC_OFS_CTRL, 8'h02, 1'b1);
        core.settle();
        check(8'(core.stall_seen), 8'h00);
        core.put(`NVC_OFS_CTRL, 8'h08, 1'b0);
        core.get(`NVC_OFS_CTRL, got);
        check(got, 8'h08);
        core.put(`NVC_OFS_DATA, 8'h5a, 1'b0);
        core.get(`NVC_OFS_CTRL, got);
        check(got, 8'h00);
        core.put(`NVC_OFS_CTRL, 8'h01, 1'b0);
        core.settle();
        check(8'(core.stall_seen), 8'h00);
        core.get(`NVC_OFS_DATA, got);
        check(got, 8'h5a);
        // A bit-set other than the unlock also drops the erase select.
        core.put(`NVC_OFS_CTRL, 8'h08, 1'b0);
        core.put(`NVC_OFS_CTRL, 8'h0a, 1'b1);
        core.settle();
        check(8'(core.stall_seen), 8'h00);
        core.get(`NVC_OFS_CTRL, got);
        check(got, 8'h00);
        // One row erased by its top address; neighbours keep their bytes.
        core.erase_row({a[5:3], 3'h7});
        for (int b = 0; b < 8; b++) mem_m[{a[5:3], 3'(b)}] = `NVC_ERASED;
        for (int i = 0; i < 64; i++) begin
            core.read_byte(6'(i), got);
            check(got, mem_m[i]);
        end
        conclude();
    end
endmodule : tb_flash_data_memory_ctrl
